/* File: logic/tmzp_defs.vh */
// Constants for the shared-prescaler timer block
// Assumes inclusion by bare name from the design files
`ifndef TMZP_DEFS_VH
`define TMZP_DEFS_VH
`define TMZP_ADDR_COUNT      8'h01
`define TMZP_ADDR_INTCTL     8'h0B
`define TMZP_ADDR_CONFIG     8'h81
`define TMZP_CFG_RESET       8'hFF
`define TMZP_INT_RESET       8'h00
`define TMZP_CFG_SRC_BIT     5
`define TMZP_CFG_EDGE_BIT    4
`define TMZP_CFG_ASSIGN_BIT  3
`define TMZP_INT_FLAG_BIT    2
`define TMZP_INT_EN_BIT      5
`define TMZP_INHIBIT_CYCLES  2'h2
`endif

/* File: logic/tmzp_prescaler.v */
// Shared 8-bit prescaler counter with ratio tap selection
// Assumes a one-cycle enable on its input and synchronous clear
`timescale 1ns/1ns
module tmzp_prescaler #(
  parameter WIDTH = 8
) (
  input  wire       clk,      // System clock
  input  wire       rst,      // Asynchronous reset, high
  input  wire       clr,      // Clear the count
  input  wire       tick_in,  // Input event
  input  wire [2:0] ratio,    // Ratio select
  input  wire       wdt_mode, // High: divide 1:1 to 1:128
  output wire       tick_out  // Divided event pulse
);
  reg  [WIDTH-1:0] count;
  wire [WIDTH-1:0] next_count;
  wire [3:0]       tap;

  assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
  assign tap        = wdt_mode ? {1'b0, ratio} : {1'b0, ratio} + 4'h1;
  // A tick leaves when all low bits below the tap roll over
  assign tick_out   = tick_in & ((tap == 4'h0) |
                      (&(count | ~((({{(WIDTH-1){1'b0}}, 1'b1}) << tap) -
                      {{(WIDTH-1){1'b0}}, 1'b1}))));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
    end else if (clr) begin
      count <= {WIDTH{1'b0}};
    end else if (tick_in) begin
      count <= next_count;
    end
  end
endmodule

/* File: logic/tmzp_timer.v */
// Operation
// - One prescaler, timer or watchdog, other unscaled
// - Prescaler count has no register address
// - Assignment and ratio from config bits 3:0
// - Count write clears prescaler when timer-assigned
// - Watchdog clear instruction clears prescaler when watchdog-assigned
// - Count write keeps assignment and ratio
// - Ratios: timer 1:2..1:256, watchdog 1:1..1:128
// - Config resets to all ones
// - Bit 5 selects instruction cycle or pin
// - Bit 4 selects rising or falling pin edge
// - Wrap FFh to 00h sets flag, enable masks
// - Count write inhibits counting two cycles
//
// Shared-prescaler 8-bit timer/counter top level
// Assumes SYS_CLK is the instruction-cycle clock and pins are synchronous
`timescale 1ns/1ns
`include "tmzp_defs.vh"
module tmzp_timer (
  input  wire       SYS_CLK,      // Instruction-cycle clock
  input  wire       SYS_RST,      // Asynchronous reset, high
  input  wire [7:0] ADDR,         // Register address
  input  wire [7:0] WDATA,        // Write data
  input  wire       WR,           // Write strobe
  input  wire       RD,           // Read strobe
  output reg  [7:0] RDATA,        // Read data, cycle after strobe
  input  wire       EXT_COUNT,    // External count input
  input  wire       WDT_CLEAR,    // Watchdog clear instruction pulse
  input  wire       WDT_TICK,     // Watchdog raw time-base tick
  output wire       WDT_TICK_OUT, // Watchdog tick after prescaling
  output wire       WDT_RESTART,  // Watchdog restart pulse
  output wire       IRQ           // Overflow interrupt, flag masked by enable bit
);
  reg  [7:0] timer_count;
  reg  [7:0] timer_prescale_config;
  reg  [7:0] interrupt_control;
  reg  [1:0] inhibit;
  reg        ext_last;
  wire       count_wr;
  wire       ctl_wr;
  wire       cfg_wr;
  wire       clock_source_select;
  wire       source_edge_select;
  wire       prescaler_assign;
  wire [2:0] prescale_ratio;
  wire       ext_edge;
  wire       src_tick;
  wire       pre_in;
  wire       pre_out;
  wire       pre_clr;
  wire       count_tick;
  wire       overflow;

  assign count_wr            = WR & (ADDR == `TMZP_ADDR_COUNT);
  assign ctl_wr              = WR & (ADDR == `TMZP_ADDR_INTCTL);
  assign cfg_wr              = WR & (ADDR == `TMZP_ADDR_CONFIG);
  assign clock_source_select = timer_prescale_config[`TMZP_CFG_SRC_BIT];
  assign source_edge_select  = timer_prescale_config[`TMZP_CFG_EDGE_BIT];
  assign prescaler_assign    = timer_prescale_config[`TMZP_CFG_ASSIGN_BIT];
  assign prescale_ratio      = timer_prescale_config[2:0];

  assign ext_edge = source_edge_select ? (ext_last & ~EXT_COUNT) :
                                         (~ext_last & EXT_COUNT);
  assign src_tick = clock_source_select ? ext_edge : 1'b1;

  assign pre_in  = prescaler_assign ? WDT_TICK : src_tick;
  assign pre_clr = prescaler_assign ? WDT_CLEAR : count_wr;
  assign WDT_TICK_OUT = prescaler_assign ? pre_out : WDT_TICK;
  assign WDT_RESTART  = WDT_CLEAR;
  assign count_tick   = (prescaler_assign ? src_tick : pre_out) & (inhibit == 2'h0);
  assign overflow     = count_tick & (timer_count == 8'hFF) & ~count_wr;
  assign IRQ = interrupt_control[`TMZP_INT_FLAG_BIT] & interrupt_control[`TMZP_INT_EN_BIT];

  tmzp_prescaler #(
    .WIDTH    (8)
  ) u_pre (
    .clk      (SYS_CLK),
    .rst      (SYS_RST),
    .clr      (pre_clr),
    .tick_in  (pre_in),
    .ratio    (prescale_ratio),
    .wdt_mode (prescaler_assign),
    .tick_out (pre_out)
  );

  always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      timer_count <= 8'h00;
      inhibit     <= 2'h0;
      ext_last    <= 1'b0;
    end else begin
      ext_last <= EXT_COUNT;
      if (count_wr) begin
        timer_count <= WDATA;
        inhibit     <= `TMZP_INHIBIT_CYCLES;
      end else begin
        if (inhibit != 2'h0) begin
          inhibit <= inhibit - 2'h1;
        end
        if (count_tick) begin
          timer_count <= timer_count + 8'h01;
        end
      end
    end
  end

  always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      timer_prescale_config <= `TMZP_CFG_RESET;
      interrupt_control     <= `TMZP_INT_RESET;
    end else begin
      if (cfg_wr) begin
        timer_prescale_config <= WDATA;
      end
      if (ctl_wr) begin
        interrupt_control <= WDATA;
      end
      // Overflow wins over a same-cycle clear
      if (overflow) begin
        interrupt_control[`TMZP_INT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `TMZP_ADDR_COUNT:  RDATA <= timer_count;
        `TMZP_ADDR_INTCTL: RDATA <= interrupt_control;
        `TMZP_ADDR_CONFIG: RDATA <= timer_prescale_config;
        default:           RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule

/* File: testbench/tmzp_timer_checker.sv */
// Port assertions for the shared-prescaler timer
// Assumes binding to tmzp_timer
`timescale 1ns/1ns
module tmzp_checker (
  input wire       SYS_CLK,      // in
  input wire       SYS_RST,      // in
  input wire [7:0] ADDR,         // in
  input wire [7:0] WDATA,        // in
  input wire       WR,           // in
  input wire       RD,           // in
  input wire [7:0] RDATA,        // in
  input wire       EXT_COUNT,    // in
  input wire       WDT_CLEAR,    // in
  input wire       WDT_TICK,     // in
  input wire       WDT_TICK_OUT, // in
  input wire       WDT_RESTART,  // in
  input wire       IRQ           // in
);
  reg [7:0] cfg;
  always @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST) cfg <= 8'hFF;
    else if (WR && ADDR == 8'h81) cfg <= WDATA;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  restart_copy_a: assert property (WDT_RESTART == WDT_CLEAR) else $error("restart");
  unmapped_read_a: assert property (RD && ADDR != 8'h01 && ADDR != 8'h0B
    && ADDR != 8'h81 |=> RDATA == 8'h00) else $error("unmapped");
  cfg_read_a: assert property (RD && ADDR == 8'h81 |=> RDATA == $past(cfg)) else $error("cfg");
  wdt_pass_a: assert property (!cfg[3] |-> WDT_TICK_OUT == WDT_TICK) else $error("wdt");
  wdt_unity_a: assert property (cfg[3:0] == 4'h8 |-> WDT_TICK_OUT == WDT_TICK) else $error("1:1");
  irq_set_a: assert property (WR && ADDR == 8'h0B && WDATA[5] && WDATA[2] |=> IRQ) else $error("irq");
  irq_mask_a: assert property (WR && ADDR == 8'h0B && !WDATA[5] |=> !IRQ) else $error("mask");
  count_hold_a: assert property ((WR && ADDR == 8'h01) ##2 (RD && ADDR == 8'h01)
    |=> RDATA == $past(WDATA, 3)) else $error("hold");
endmodule
bind tmzp_timer tmzp_checker u_chk (.*);

/* File: testbench/tmzp_far_side.sv */
// Count pin source and watchdog time base
// Assumes the bench clock; pin period six cycles, tick every second cycle
`timescale 1ns/1ns
module tmzp_far_side (
  input  wire clk,  // Clock
  output reg  pin,  // Count pin
  output reg  tick  // Watchdog tick
);
  reg [2:0] cnt = 3'h0;
  initial pin = 1'b0;
  initial tick = 1'b0;
  always @(posedge clk) begin
    cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
    pin <= (cnt < 3'h3);
    tick <= cnt[0];
  end
endmodule

/* File: testbench/tb_timer0_shared_prescaler.sv */
// Bench: config reset value, unmapped read, count write hold, overflow interrupt, ratios and sources
// Assumes the far-side model drives the pin and the watchdog tick
`timescale 1ns/1ns
module tb_timer0_shared_prescaler;
  reg        clk = 0, rst = 1, wr = 0, rd = 0, wclr = 0;
  reg  [7:0] addr = 8'h00, wdata = 8'h00, a, b, c, nt;
  reg [15:0] seed = 16'hF6D4;
  wire [7:0] rdata;
  wire       pin, tick, tout, rstrt, irq;
  integer    n_mismatch = 0, comparisons = 0, i, p;
  tmzp_far_side u_far (.clk(clk), .pin(pin), .tick(tick));
  tmzp_timer u_dut (.SYS_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .EXT_COUNT(pin), .WDT_CLEAR(wclr), .WDT_TICK(tick),
    .WDT_TICK_OUT(tout), .WDT_RESTART(rstrt), .IRQ(irq));
  function [15:0] xs(input [15:0] x);
    xs = x ^ (x << 7) ^ ((x ^ (x << 7)) >> 9);
  endfunction
  function integer per(input [7:0] f);
    per = (f[5] ? 6 : 1) * (f[3] ? 1 : 2 << f[2:0]);
  endfunction
  task wreg(input [7:0] ad, input [7:0] d);
    begin @(posedge clk); wr <= 1; addr <= ad; wdata <= d; @(posedge clk); wr <= 0; #1; end
  endtask
  task rreg(input [7:0] ad, output [7:0] d);
    begin @(posedge clk); rd <= 1; addr <= ad; @(posedge clk); rd <= 0; #1 d = rdata; end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("%0d compared, %0d mismatched", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always #2 clk = ~clk;
  initial begin #360000; n_mismatch = n_mismatch + 1; end_sim; end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rreg(8'h81, a); chk(a, 8'hFF);
    rreg(8'h02, a); chk(a, 8'h00);
    wreg(8'h81, 8'h08);
    wreg(8'h0B, 8'h20);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      b = i ? seed[7:0] : 8'hFF;
      wreg(8'h01, b);
      rreg(8'h01, a); chk(a, b);
      rreg(8'h01, a); chk(a, b + 8'h01);
      if (i == 0) chk({7'h00, irq}, 8'h01);
    end
    wreg(8'h01, 8'h00);
    wreg(8'h0B, 8'h20); chk({7'h00, irq}, 8'h00);
    wreg(8'h0B, 8'h24); chk({7'h00, irq}, 8'h01);
    wreg(8'h0B, 8'h00);
    $display("count test done");
    for (i = 0; i < 14; i = i + 1) begin
      seed = xs(seed);
      b = (i < 8) ? i : (i == 13) ? 8'h2F : {2'h0, seed[5:0]};
      if (b[3]) wreg(8'h01, 8'h00);
      wreg(8'h81, b);
      @(posedge clk) wclr <= 1;
      #1 chk({7'h00, rstrt}, 8'h01);
      @(posedge clk) wclr <= 0;
      if (b[3]) begin
        nt = 8'h00;
        repeat (4 * (2 << b[2:0])) @(posedge clk) #1 nt = nt + tout;
        chk(nt, 8'h04);
      end
      p = 2 * per(b);
      rreg(8'h01, a);
      repeat (p - 2) @(posedge clk);
      rreg(8'h01, c); chk(c - a, 8'h02);
    end
    $display("ratio test done");
    end_sim;
  end
endmodule
